// >>> hdl/cfg_regs_pkg.sv
// constants for the configuration and control register bank
`default_nettype none
package cfg_regs_pkg;
   // register select codes on the register port
   localparam int          SEL_W           = 2;
   localparam logic [1:0]  SEL_CFG_WORD3   = 2'h0;
   localparam logic [1:0]  SEL_CFG_CONTROL = 2'h1;
   localparam logic [1:0]  SEL_REV_IDENT   = 2'h2;
   // configuration word fields
   localparam int          CW_USB_ID_OWNER = 30;
   localparam int          CW_REMAP_ONCE   = 29;
   localparam int          CW_MODDIS_ONCE  = 28;
   localparam int          CW_I2C2_ALT     = 23;
   localparam int          CW_I2C1_ALT     = 22;
   localparam int          CW_USER_ID_LSB  = 0;
   localparam int          CW_USER_ID_W    = 16;
   // control register fields
   localparam int          CC_REMAP_LOCK   = 13;
   localparam int          CC_MODDIS_LOCK  = 12;
   localparam int          CC_FLASH_LP     = 8;
   localparam int          CC_TEST_PORT    = 3;
   localparam int          CC_TWO_WIRE_TDO = 0;
   localparam logic [31:0] CC_FIXED_ONES   = 32'h0000_0006;
   localparam logic        CC_REMAP_LOCK_RST  = 1'b0;
   localparam logic        CC_MODDIS_LOCK_RST = 1'b0;
   localparam logic        CC_FLASH_LP_RST    = 1'b1;
   localparam logic        CC_TEST_PORT_RST   = 1'b1;
   localparam logic        CC_TDO_RST         = 1'b1;
   // identification register fields
   localparam int          ID_REV_LSB      = 28;
   localparam int          ID_REV_W        = 4;
   localparam int          ID_DEV_W        = 28;
   // configuration word value before it is loaded
   localparam logic [31:0] CW_BLANK        = 32'hFFFF_FFFF;
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_REQ  = 2'b01,
      LD_WAIT = 2'b10,
      LD_DONE = 2'b11
   } load_state_t;
endpackage
`default_nettype wire

// >>> hdl/cfg_word_loader.sv
// fetches the configuration word from nonvolatile storage after reset
`default_nettype none
module cfg_word_loader (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // nonvolatile storage read port
   output logic             nvm_rd_q,
   input  wire logic        nvm_valid,
   input  wire logic [31:0] nvm_data,
   // loaded word
   output logic [31:0]      word_q,
   output logic             loaded_q
);
   import cfg_regs_pkg::*;

   load_state_t state_q;
   load_state_t state_d;
   wire         take = (state_q == LD_WAIT) && nvm_valid;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LD_IDLE: state_d = LD_REQ;
         LD_REQ:  state_d = LD_WAIT;
         LD_WAIT: if (nvm_valid) state_d = LD_DONE;
         LD_DONE: state_d = LD_DONE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q  <= LD_IDLE;
         nvm_rd_q <= 1'b0;
         word_q   <= CW_BLANK;
         loaded_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         nvm_rd_q <= (state_d == LD_REQ);
         if (take) word_q <= nvm_data;
         loaded_q <= loaded_q | take;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/device_config_control_regs.sv
// configuration word, configuration control and identification registers
// Summary of operation
// - usb identity pin goes to the usb unit when config bit 30 is set
// - config bit 29 set allows only one pin remap reconfiguration
// - config bit 28 set allows only one module disable reconfiguration
// - config bit 23 set puts second i2c on primary pins, else alternate
// - config bit 22 set puts first i2c on primary pins, else alternate
// - config bits 15:0 are a user id, hidden from software under code protect
// - control bit 13 resets 0; when set, pin remap writes are blocked
// - control bit 12 resets 0; when set, module disable writes are ignored
// - control bit 8 resets 1, enabling low-power flash read
// - control bit 3 resets 1, enabling the test port
// - control bit 0 resets 1, two-wire test protocol uses tdo
// - control bits 31:14 and 11:9 read zero and ignore writes
// - identification register holds revision 31:28 and device id 27:0
`default_nettype none
module device_config_control_regs #(
   parameter logic [3:0]  SILICON_REVISION = 4'h1,       // arbitrary value
   parameter logic [27:0] DEVICE_IDENT     = 28'h0000001 // arbitrary value
) (
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // register port
   input  wire logic [cfg_regs_pkg::SEL_W-1:0] reg_sel,
   input  wire logic                         reg_wr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_rd,
   input  wire logic                         reg_from_debug,
   output logic [31:0]                       reg_rdata_q,
   output logic                              reg_rvalid_q,
   // system state
   input  wire logic                         sys_unlocked,
   input  wire logic                         code_protect,
   // nonvolatile storage
   output logic                              nvm_rd_q,
   input  wire logic                         nvm_valid,
   input  wire logic [31:0]                  nvm_data,
   output logic                              exec_enable_q,
   // pin remap and module disable write gating
   input  wire logic                         remap_wr_req,
   output logic                              remap_wr_grant_q,
   input  wire logic                         moddis_wr_req,
   output logic                              moddis_wr_grant_q,
   // configuration outputs
   output logic                              usb_id_by_usb_q,
   output logic                              i2c1_primary_q,
   output logic                              i2c2_primary_q,
   output logic                              flash_low_power_read_q,
   output logic                              test_port_enable_q,
   output logic                              two_wire_tdo_use_q
);
   import cfg_regs_pkg::*;

   // one flag placed at its position in a register image
   function automatic logic [31:0] bit_at(input logic flag, input int pos);
      bit_at      = 32'h0000_0000;
      bit_at[pos] = flag;
   endfunction

   // internal state and next values
   logic [31:0] cfg_word;
   logic        cfg_loaded;
   logic        remap_lock_q;
   logic        remap_lock_d;
   logic        moddis_lock_q;
   logic        moddis_lock_d;
   logic        remap_used_q;
   logic        remap_used_d;
   logic        moddis_used_q;
   logic        moddis_used_d;
   logic        flash_lp_q;
   logic        flash_lp_d;
   logic        test_port_q;
   logic        test_port_d;
   logic        tdo_use_q;
   logic        tdo_use_d;
   logic [31:0] rdata_d;
   logic        usb_id_d;
   logic        i2c1_primary_d;
   logic        i2c2_primary_d;
   logic        remap_grant_d;
   logic        moddis_grant_d;

   cfg_word_loader cfg_word_loader_inst (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .nvm_rd_q  (nvm_rd_q),
      .nvm_valid (nvm_valid),
      .nvm_data  (nvm_data),
      .word_q    (cfg_word),
      .loaded_q  (cfg_loaded)
   );

   // register select decode
   wire sel_cw = (reg_sel == SEL_CFG_WORD3);
   wire sel_cc = (reg_sel == SEL_CFG_CONTROL);
   wire sel_id = (reg_sel == SEL_REV_IDENT);
   wire wr_cc  = reg_wr && sel_cc;

   // one-shot mode: once a lock has been set it stays set until reset
   wire remap_once    = cfg_word[CW_REMAP_ONCE];
   wire moddis_once   = cfg_word[CW_MODDIS_ONCE];
   wire remap_frozen  = remap_once && remap_used_q;
   wire moddis_frozen = moddis_once && moddis_used_q;

   // lock bits move only after the unlock sequence
   wire lock_wr_ok     = wr_cc && sys_unlocked;
   wire remap_lock_wr  = lock_wr_ok && !remap_frozen;
   wire moddis_lock_wr = lock_wr_ok && !moddis_frozen;

   assign remap_lock_d  = remap_lock_wr ? reg_wdata[CC_REMAP_LOCK] : remap_lock_q;
   assign moddis_lock_d = moddis_lock_wr ? reg_wdata[CC_MODDIS_LOCK] : moddis_lock_q;
   assign remap_used_d  = remap_used_q | remap_lock_d;
   assign moddis_used_d = moddis_used_q | moddis_lock_d;

   // plain control bits need no unlock
   assign flash_lp_d  = wr_cc ? reg_wdata[CC_FLASH_LP] : flash_lp_q;
   assign test_port_d = wr_cc ? reg_wdata[CC_TEST_PORT] : test_port_q;
   assign tdo_use_d   = wr_cc ? reg_wdata[CC_TWO_WIRE_TDO] : tdo_use_q;

   // control register readback, unimplemented positions fixed
   wire [31:0] cc_read = CC_FIXED_ONES
                       | bit_at(remap_lock_q, CC_REMAP_LOCK)
                       | bit_at(moddis_lock_q, CC_MODDIS_LOCK)
                       | bit_at(flash_lp_q, CC_FLASH_LP)
                       | bit_at(test_port_q, CC_TEST_PORT)
                       | bit_at(tdo_use_q, CC_TWO_WIRE_TDO);

   // user id hidden from run-time software while code protection is on
   wire        hide_uid = code_protect && !reg_from_debug;
   wire [31:0] cw_read  = hide_uid ? {cfg_word[31:CW_USER_ID_W], 16'h0000} : cfg_word;
   wire [31:0] id_read  = {SILICON_REVISION, DEVICE_IDENT};

   // configuration word has no write path; unmapped select reads zero
   wire [31:0] rd_mux = sel_cw ? cw_read :
                        sel_cc ? cc_read :
                        sel_id ? id_read : 32'h0000_0000;

   assign rdata_d = reg_rd ? rd_mux : reg_rdata_q;

   // pin routing keeps its reset value until the word has been loaded
   assign usb_id_d       = cfg_loaded ? cfg_word[CW_USB_ID_OWNER] : usb_id_by_usb_q;
   assign i2c1_primary_d = cfg_loaded ? cfg_word[CW_I2C1_ALT] : i2c1_primary_q;
   assign i2c2_primary_d = cfg_loaded ? cfg_word[CW_I2C2_ALT] : i2c2_primary_q;

   // write gating toward pin remap and module disable registers
   assign remap_grant_d  = remap_wr_req && !remap_lock_q;
   assign moddis_grant_d = moddis_wr_req && !moddis_lock_q;

   // lock and one-shot state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         remap_lock_q <= CC_REMAP_LOCK_RST;
      end else begin
         remap_lock_q <= remap_lock_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         moddis_lock_q <= CC_MODDIS_LOCK_RST;
      end else begin
         moddis_lock_q <= moddis_lock_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         remap_used_q <= 1'b0;
      end else begin
         remap_used_q <= remap_used_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         moddis_used_q <= 1'b0;
      end else begin
         moddis_used_q <= moddis_used_d;
      end
   end

   // control bits
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flash_lp_q <= CC_FLASH_LP_RST;
      end else begin
         flash_lp_q <= flash_lp_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         test_port_q <= CC_TEST_PORT_RST;
      end else begin
         test_port_q <= test_port_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tdo_use_q <= CC_TDO_RST;
      end else begin
         tdo_use_q <= tdo_use_d;
      end
   end

   // register read port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         remap_wr_grant_q <= 1'b0;
      end else begin
         remap_wr_grant_q <= remap_grant_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         moddis_wr_grant_q <= 1'b0;
      end else begin
         moddis_wr_grant_q <= moddis_grant_d;
      end
   end

   // code held until the word is in
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exec_enable_q <= 1'b0;
      end else begin
         exec_enable_q <= cfg_loaded;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         usb_id_by_usb_q <= 1'b0;
      end else begin
         usb_id_by_usb_q <= usb_id_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         i2c1_primary_q <= 1'b1;
      end else begin
         i2c1_primary_q <= i2c1_primary_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         i2c2_primary_q <= 1'b1;
      end else begin
         i2c2_primary_q <= i2c2_primary_d;
      end
   end

   // registered copies of the control bits
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flash_low_power_read_q <= CC_FLASH_LP_RST;
      end else begin
         flash_low_power_read_q <= flash_lp_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         test_port_enable_q <= CC_TEST_PORT_RST;
      end else begin
         test_port_enable_q <= test_port_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         two_wire_tdo_use_q <= CC_TDO_RST;
      end else begin
         two_wire_tdo_use_q <= tdo_use_q;
      end
   end
endmodule
`default_nettype wire

// >>> bench/device_config_control_regs_asserts.sv
// port checker for the configuration and control register bank
`default_nettype none
module device_config_control_regs_asserts #(
   parameter logic [3:0]  SILICON_REVISION = 4'h1,
   parameter logic [27:0] DEVICE_IDENT     = 28'h0000001
) (
   // clock and reset
   input wire logic                             clk_sys,
   input wire logic                             rst,
   // register port
   input wire logic [cfg_regs_pkg::SEL_W-1:0]   reg_sel,
   input wire logic                             reg_rd,
   input wire logic                             reg_from_debug,
   input wire logic                             code_protect,
   input wire logic [31:0]                      reg_rdata_q,
   // storage and gating
   input wire logic                             nvm_valid,
   input wire logic                             exec_enable_q,
   input wire logic                             remap_wr_req,
   input wire logic                             remap_wr_grant_q,
   input wire logic                             moddis_wr_req,
   input wire logic                             moddis_wr_grant_q,
   input wire logic                             usb_id_by_usb_q
);
   import cfg_regs_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_ident_value: assert property (reg_rd && reg_sel == SEL_REV_IDENT |=>
      reg_rdata_q == {SILICON_REVISION, DEVICE_IDENT}) else $error("ident read wrong");
   chk_ctrl_zero_bits: assert property (reg_rd && reg_sel == SEL_CFG_CONTROL |=>
      reg_rdata_q[31:14] == 18'h0 && reg_rdata_q[11:9] == 3'h0) else $error("ctrl gaps set");
   chk_user_id_hidden: assert property (reg_rd && reg_sel == SEL_CFG_WORD3 && code_protect
      && !reg_from_debug && exec_enable_q |=> reg_rdata_q[15:0] == 16'h0)
      else $error("user id leaked");
   chk_remap_grant_cause: assert property (remap_wr_grant_q |-> $past(remap_wr_req))
      else $error("remap grant without request");
   chk_moddis_grant_cause: assert property (moddis_wr_grant_q |-> $past(moddis_wr_req))
      else $error("moddis grant without request");
   chk_exec_after_load: assert property ($rose(exec_enable_q) |-> $past(nvm_valid, 2))
      else $error("exec not two cycles after valid");
   chk_exec_stays_on: assert property (exec_enable_q |=> exec_enable_q)
      else $error("exec dropped");
   chk_usb_owner_frozen: assert property (exec_enable_q && $past(exec_enable_q) |->
      $stable(usb_id_by_usb_q)) else $error("usb owner changed");
   cov_remap_grant: cover property (remap_wr_grant_q);
   cov_load_done: cover property ($rose(exec_enable_q));
   cov_ident_read: cover property (reg_rd && reg_sel == SEL_REV_IDENT);
endmodule
bind device_config_control_regs device_config_control_regs_asserts #(
   .SILICON_REVISION (SILICON_REVISION),
   .DEVICE_IDENT     (DEVICE_IDENT)
) device_config_control_regs_asserts_inst (
   .clk_sys           (clk_sys),
   .rst               (rst),
   .reg_sel           (reg_sel),
   .reg_rd            (reg_rd),
   .reg_from_debug    (reg_from_debug),
   .code_protect      (code_protect),
   .reg_rdata_q       (reg_rdata_q),
   .nvm_valid         (nvm_valid),
   .exec_enable_q     (exec_enable_q),
   .remap_wr_req      (remap_wr_req),
   .remap_wr_grant_q  (remap_wr_grant_q),
   .moddis_wr_req     (moddis_wr_req),
   .moddis_wr_grant_q (moddis_wr_grant_q),
   .usb_id_by_usb_q   (usb_id_by_usb_q)
);
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the configuration and control register bank
`default_nettype none
`define CMP(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_regs_pkg::*;
   // reserved positions of both words programmed as ones
   localparam logic [31:0] WORD  = 32'hEF7F1234;
   localparam logic [31:0] WORD2 = 32'h9FBFA5C3;
   int          n_errors = 0;
   int          n_checks = 0;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  reg_sel = 2'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] nvm_data = 32'h0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_from_debug = 1'b0, nvm_valid = 1'b0;
   logic        sys_unlocked = 1'b0, code_protect = 1'b0;
   logic        remap_wr_req = 1'b0, moddis_wr_req = 1'b0;
   logic [31:0] reg_rdata_q;
   logic        reg_rvalid_q, nvm_rd_q, exec_enable_q, remap_wr_grant_q, moddis_wr_grant_q;
   logic        usb_id_by_usb_q, i2c1_primary_q, i2c2_primary_q;
   logic        flash_low_power_read_q, test_port_enable_q, two_wire_tdo_use_q;
   device_config_control_regs device_config_control_regs_inst (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .reg_sel                (reg_sel),
      .reg_wr                 (reg_wr),
      .reg_wdata              (reg_wdata),
      .reg_rd                 (reg_rd),
      .reg_from_debug         (reg_from_debug),
      .reg_rdata_q            (reg_rdata_q),
      .reg_rvalid_q           (reg_rvalid_q),
      .sys_unlocked           (sys_unlocked),
      .code_protect           (code_protect),
      .nvm_rd_q               (nvm_rd_q),
      .nvm_valid              (nvm_valid),
      .nvm_data               (nvm_data),
      .exec_enable_q          (exec_enable_q),
      .remap_wr_req           (remap_wr_req),
      .remap_wr_grant_q       (remap_wr_grant_q),
      .moddis_wr_req          (moddis_wr_req),
      .moddis_wr_grant_q      (moddis_wr_grant_q),
      .usb_id_by_usb_q        (usb_id_by_usb_q),
      .i2c1_primary_q         (i2c1_primary_q),
      .i2c2_primary_q         (i2c2_primary_q),
      .flash_low_power_read_q (flash_low_power_read_q),
      .test_port_enable_q     (test_port_enable_q),
      .two_wire_tdo_use_q     (two_wire_tdo_use_q)
   );
   always #20 clk_sys = ~clk_sys;
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [1:0] sel, input logic [31:0] ex, input string nm);
      @(negedge clk_sys);
      reg_sel = sel;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      `CMP(nm, ex, reg_rdata_q)
      `CMP("rvalid", 1'b1, reg_rvalid_q)
   endtask
   task automatic wr(input logic [1:0] sel, input logic [31:0] d);
      @(negedge clk_sys);
      reg_sel = sel;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic gr(input logic moddis, input logic ex);
      @(negedge clk_sys);
      remap_wr_req = !moddis;
      moddis_wr_req = moddis;
      @(negedge clk_sys);
      remap_wr_req = 1'b0;
      moddis_wr_req = 1'b0;
      `CMP("grant", ex, moddis ? moddis_wr_grant_q : remap_wr_grant_q)
   endtask
   task automatic t_reset();
      @(negedge clk_sys);
      `CMP("nvm rd", 1'b1, nvm_rd_q)
      `CMP("pins reset", 3'b011, {usb_id_by_usb_q, i2c1_primary_q, i2c2_primary_q})
      @(negedge clk_sys);
      `CMP("nvm rd end", 1'b0, nvm_rd_q)
      rd(SEL_CFG_CONTROL, 32'h0000010F, "ctrl reset");
      `CMP("ctrl outs", 3'b111, {flash_low_power_read_q, test_port_enable_q, two_wire_tdo_use_q})
      rd(SEL_CFG_WORD3, 32'hFFFFFFFF, "word blank");
      `CMP("exec early", 1'b0, exec_enable_q)
   endtask
   task automatic t_load();
      @(negedge clk_sys);
      nvm_data = WORD;
      nvm_valid = 1'b1;
      @(negedge clk_sys);
      nvm_valid = 1'b0;
      `CMP("exec one", 1'b0, exec_enable_q)
      @(negedge clk_sys);
      `CMP("exec", 1'b1, exec_enable_q)
      `CMP("pins", 3'b110, {usb_id_by_usb_q, i2c1_primary_q, i2c2_primary_q})
      code_protect = 1'b1;
      rd(SEL_CFG_WORD3, WORD & 32'hFFFF0000, "word hidden");
      reg_from_debug = 1'b1;
      rd(SEL_CFG_WORD3, WORD, "word debug");
      code_protect = 1'b0;
      reg_from_debug = 1'b0;
      wr(SEL_CFG_WORD3, 32'h0);
      rd(SEL_CFG_WORD3, WORD, "word sw");
      rd(SEL_REV_IDENT, 32'h10000001, "ident");
      rd(2'h3, 32'h0, "unmapped");
   endtask
   task automatic t_locks();
      wr(SEL_CFG_CONTROL, 32'hFFFFFFFF);
      rd(SEL_CFG_CONTROL, 32'h0000010F, "ctrl locked ones");
      wr(SEL_CFG_CONTROL, 32'h0);
      rd(SEL_CFG_CONTROL, 32'h00000006, "ctrl cleared");
      `CMP("ctrl outs", 3'b000, {flash_low_power_read_q, test_port_enable_q, two_wire_tdo_use_q})
      gr(1'b0, 1'b1);
      gr(1'b1, 1'b1);
      sys_unlocked = 1'b1;
      wr(SEL_CFG_CONTROL, 32'h3000);
      rd(SEL_CFG_CONTROL, 32'h00003006, "locks set");
      gr(1'b0, 1'b0);
      gr(1'b1, 1'b0);
      wr(SEL_CFG_CONTROL, 32'h0);
      rd(SEL_CFG_CONTROL, 32'h00002006, "one shot");
      gr(1'b1, 1'b1);
   endtask
   task automatic t_reload();
      @(negedge clk_sys);
      nvm_data = WORD2;
      nvm_valid = 1'b1;
      @(negedge clk_sys);
      nvm_valid = 1'b0;
      rd(SEL_CFG_WORD3, WORD, "word once");
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      rd(SEL_CFG_CONTROL, 32'h0000010F, "ctrl again");
      rd(SEL_CFG_WORD3, CW_BLANK, "word blank again");
      @(negedge clk_sys);
      nvm_valid = 1'b1;
      @(negedge clk_sys);
      nvm_valid = 1'b0;
      @(negedge clk_sys);
      `CMP("exec two", 1'b1, exec_enable_q)
      `CMP("pins two", 3'b001, {usb_id_by_usb_q, i2c1_primary_q, i2c2_primary_q})
      sys_unlocked = 1'b1;
      wr(SEL_CFG_CONTROL, 32'h3000);
      wr(SEL_CFG_CONTROL, 32'h0);
      rd(SEL_CFG_CONTROL, 32'h00001006, "one shot two");
      gr(1'b0, 1'b1);
      gr(1'b1, 1'b0);
   endtask
   initial begin
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      t_load();
      t_locks();
      t_reload();
      close_out();
   end
   initial begin
      #20us;
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire
